// *** core/serial_bus_params.svh ***
// register offsets, field positions, reset values and timing counts
// assumes a 125 MHz core clock and byte addressing on the register bus
`ifndef SERIAL_BUS_PARAMS_SVH
`define SERIAL_BUS_PARAMS_SVH

// register byte offsets
`define ADDR_PROTO_CTRL   12'h000
`define ADDR_XFER_CTRL    12'h004
`define ADDR_SHIFT_DATA   12'h008

// protocol control fields
`define PROTO_VARIANT_BIT 0
`define PROTO_SELECT_BIT  1
`define PROTO_STOP_BIT    2
`define PROTO_START_BIT   3

// transfer control fields
`define XFER_BUSY_BIT     0
`define XFER_NOACK_BIT    1
`define XFER_VERIFY_BIT   2
`define XFER_DIR_BIT      3

// reset values
`define PROTO_CTRL_RESET  4'h0
`define SHIFT_DATA_RESET  8'h00

// timing
`define CLK_PERIOD_NS     8
`define SCL_PERIOD_NS     16000
`define GLITCH_NS         50
`define QUARTER_CYCLES    (`SCL_PERIOD_NS / (4 * `CLK_PERIOD_NS))
`define GLITCH_CYCLES     ((`GLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** core/serial_bus_pkg.sv ***
// types shared by the serial bus master port
// assumes nothing beyond a SystemVerilog compiler
package serial_bus_pkg;

    typedef enum logic [1:0] {
        MODE_OFF   = 2'b00,
        MODE_SHIFT = 2'b01,
        MODE_I2C   = 2'b10,
        MODE_3WIRE = 2'b11
    } bus_mode_e;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_START = 3'b001,
        ST_BIT   = 3'b010,
        ST_STOP  = 3'b011,
        ST_DONE  = 3'b100
    } xfer_state_e;

endpackage

// *** core/glitch_filter.sv ***
// two-stage synchroniser followed by a stability filter
// assumes an asynchronous pin input; idles high like an open-drain line
`include "serial_bus_params.svh"

module glitch_filter (
    input  wire logic mclk,     // core clock
    input  wire logic rst_n,    // async reset, active low
    input  wire logic ce,       // clock enable
    input  wire logic pinIn,    // raw pin level
    output logic      level     // filtered level
);
    localparam logic [3:0] LAST = 4'(`GLITCH_CYCLES - 1);

    logic       sync1_q;
    logic       sync2_q;
    logic [3:0] cnt_q;
    wire        differs = sync2_q != level;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
        end else if (ce) begin
            sync1_q <= pinIn;
            sync2_q <= sync1_q;
        end
    end

    // a change is accepted only after it has held for the full window
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 4'h0;
            level <= 1'b1;
        end else if (ce) begin
            if (!differs) begin
                cnt_q <= 4'h0;
            end else if (cnt_q == LAST) begin
                cnt_q <= 4'h0;
                level <= sync2_q;
            end else begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end
endmodule

// *** core/quarter_tick.sv ***
// quarter-period timer for the serial clock
// assumes run is held low to restart the count
`include "serial_bus_params.svh"

module quarter_tick (
    input  wire logic mclk,     // core clock
    input  wire logic rst_n,    // async reset, active low
    input  wire logic ce,       // clock enable
    input  wire logic run,      // count while high
    output logic      tick      // one-cycle pulse per quarter
);
    localparam logic [8:0] LAST = 9'(`QUARTER_CYCLES - 1);

    logic [8:0] cnt_q;

    assign tick = run && (cnt_q == LAST);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 9'h000;
        end else if (ce) begin
            if (!run || tick) begin
                cnt_q <= 9'h000;
            end else begin
                cnt_q <= cnt_q + 9'h001;
            end
        end
    end
endmodule

// *** core/serial_bus_master_port.sv ***
// single-master serial port: two-wire, three-wire and shift-register modes
// assumes an APB master on mclk and open-drain pins resolved outside
//
// Decided for this implementation: the APB register port and the register addresses.
`include "serial_bus_params.svh"

module serial_bus_master_port (
    input  wire logic        mclk,           // core clock, 125 MHz
    input  wire logic        rst_n,          // async reset, active low
    input  wire logic        ce,             // clock enable
    input  wire logic        psel,           // apb select
    input  wire logic        penable,        // apb enable
    input  wire logic        pwrite,         // apb write
    input  wire logic [11:0] paddr,          // apb byte address
    input  wire logic [31:0] pwdata,         // apb write data
    output logic      [31:0] prdata,         // apb read data
    output logic             pready,         // apb ready
    output logic             pslverr,        // apb error
    input  wire logic        sclIn,          // clock pin level
    output logic             sclOut,         // clock pin value
    output logic             sclOe,          // clock pin pulled low
    input  wire logic        sdaIn,          // data pin level
    output logic             sdaOut,         // data pin value
    output logic             sdaOe,          // data pin pulled low
    output logic             enableLineOut,  // enable pin value
    output logic             enableLineOe,   // enable pin pulled low
    output logic             vsyncIntEnable  // vertical sync irq enable
);

    ////////////////////////////////////////////////////////////////////
    // register state

    logic       busVariantSelect_q;
    logic       protocolSelect_q;
    logic       stopGenEnable_q;
    logic       startGenEnable_q;
    logic       transferDirection_q;
    logic       verifyFlag_q;
    logic       noAckFlag_q;
    logic       transferBusy_q;
    logic [7:0] serialShiftData_q;

    serial_bus_pkg::xfer_state_e state_q;
    serial_bus_pkg::xfer_state_e state_d;
    logic [1:0] phase_q;
    logic [3:0] bitCnt_q;

    logic sclLowD;
    logic sdaLowD;
    logic enLowD;

    ////////////////////////////////////////////////////////////////////
    // mode decode and filtered pins

    serial_bus_pkg::bus_mode_e mode;
    assign mode = serial_bus_pkg::bus_mode_e'(
        {protocolSelect_q, busVariantSelect_q});

    wire modeOff   = mode == serial_bus_pkg::MODE_OFF;
    wire shiftMode = mode == serial_bus_pkg::MODE_SHIFT;
    wire threeWire = mode == serial_bus_pkg::MODE_3WIRE;
    wire busMode   = protocolSelect_q;

    logic sclF;
    logic sdaF;

    glitch_filter sclFilter (
        .mclk  (mclk),
        .rst_n (rst_n),
        .ce    (ce),
        .pinIn (sclIn),
        .level (sclF)
    );

    glitch_filter sdaFilter (
        .mclk  (mclk),
        .rst_n (rst_n),
        .ce    (ce),
        .pinIn (sdaIn),
        .level (sdaF)
    );

    ////////////////////////////////////////////////////////////////////
    // apb decode

    wire accessPhase = psel && penable;
    wire firstAccess = accessPhase && !pready;
    wire take        = accessPhase && pready;
    wire selProto    = paddr == `ADDR_PROTO_CTRL;
    wire selXfer     = paddr == `ADDR_XFER_CTRL;
    wire selData     = paddr == `ADDR_SHIFT_DATA;
    wire dataBlocked = selData && transferBusy_q;
    wire accessErr   = !(selProto || selXfer || selData) || dataBlocked;
    wire doWrite     = take && pwrite && !pslverr;
    wire wrProto     = doWrite && selProto;
    wire wrXfer      = doWrite && selXfer;
    wire wrData      = doWrite && selData;

    wire [31:0] protoRead = {28'h0000000, startGenEnable_q,
        stopGenEnable_q, protocolSelect_q, busVariantSelect_q};
    // direction is write-only and reads as zero
    wire [31:0] xferRead  = {28'h0000000, 1'b0, verifyFlag_q,
        noAckFlag_q, transferBusy_q};
    wire [31:0] dataRead  = {24'h000000, serialShiftData_q};
    wire [31:0] readMux   = selProto ? protoRead :
                            selXfer  ? xferRead  :
                            (selData && !dataBlocked) ? dataRead :
                            32'h00000000;

    // busy can only be started on an enabled, idle port
    wire startByte = wrXfer && pwdata[`XFER_BUSY_BIT] && !modeOff
                     && !transferBusy_q;
    wire newDir    = pwdata[`XFER_DIR_BIT];

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else if (ce) begin
            pready  <= firstAccess;
            pslverr <= firstAccess && accessErr;
            prdata  <= firstAccess ? readMux : 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // control registers

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            busVariantSelect_q <= 1'b0;
            protocolSelect_q   <= 1'b0;
            stopGenEnable_q    <= 1'b0;
            startGenEnable_q   <= 1'b0;
        end else if (ce && wrProto) begin
            busVariantSelect_q <= pwdata[`PROTO_VARIANT_BIT];
            protocolSelect_q   <= pwdata[`PROTO_SELECT_BIT]
                                  | pwdata[`PROTO_STOP_BIT]
                                  | pwdata[`PROTO_START_BIT];
            stopGenEnable_q    <= pwdata[`PROTO_STOP_BIT];
            startGenEnable_q   <= pwdata[`PROTO_START_BIT];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            transferDirection_q <= 1'b0;
            vsyncIntEnable      <= 1'b0;
        end else if (ce && wrXfer) begin
            transferDirection_q <= newDir;
            vsyncIntEnable      <= pwdata[`XFER_VERIFY_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // bit timing

    wire waitHigh = (state_q == serial_bus_pkg::ST_START
                     || state_q == serial_bus_pkg::ST_BIT)
                    && phase_q == 2'd2 && busMode && !sclF;
    wire runTimer = transferBusy_q && !waitHigh
                    && state_q != serial_bus_pkg::ST_IDLE
                    && state_q != serial_bus_pkg::ST_DONE;
    logic tick;

    quarter_tick bitTimer (
        .mclk  (mclk),
        .rst_n (rst_n),
        .ce    (ce),
        .run   (runTimer),
        .tick  (tick)
    );

    wire ackBit    = bitCnt_q == 4'd8;
    wire lastBit   = shiftMode ? (bitCnt_q == 4'd7) : ackBit;
    wire bitEnd    = tick && state_q == serial_bus_pkg::ST_BIT
                     && phase_q == 2'd3;
    wire dataEnd   = bitEnd && !ackBit;
    wire txData    = transferDirection_q && !ackBit;

    ////////////////////////////////////////////////////////////////////
    // sequencer

    always_comb begin
        state_d = state_q;
        case (state_q)
            serial_bus_pkg::ST_IDLE: begin
                if (startByte) begin
                    state_d = (busMode && startGenEnable_q)
                              ? serial_bus_pkg::ST_START
                              : serial_bus_pkg::ST_BIT;
                end
            end
            serial_bus_pkg::ST_START: begin
                if (tick && phase_q == 2'd3) begin
                    state_d = serial_bus_pkg::ST_BIT;
                end
            end
            serial_bus_pkg::ST_BIT: begin
                if (bitEnd && lastBit) begin
                    state_d = (busMode && stopGenEnable_q)
                              ? serial_bus_pkg::ST_STOP
                              : serial_bus_pkg::ST_DONE;
                end
            end
            serial_bus_pkg::ST_STOP: begin
                if (tick && phase_q == 2'd3) begin
                    state_d = serial_bus_pkg::ST_DONE;
                end
            end
            serial_bus_pkg::ST_DONE: begin
                state_d = serial_bus_pkg::ST_IDLE;
            end
            default: begin
                state_d = serial_bus_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= serial_bus_pkg::ST_IDLE;
            phase_q <= 2'd0;
            bitCnt_q <= 4'd0;
        end else if (ce) begin
            state_q <= state_d;
            if (state_d != state_q) begin
                phase_q  <= 2'd0;
                bitCnt_q <= 4'd0;
            end else if (bitEnd) begin
                phase_q  <= 2'd0;
                bitCnt_q <= bitCnt_q + 4'd1;
            end else if (tick) begin
                phase_q  <= phase_q + 2'd1;
            end
        end
    end

    // busy held through the acknowledge clock and any stop
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            transferBusy_q <= 1'b0;
        end else if (ce) begin
            if (startByte) begin
                transferBusy_q <= 1'b1;
            end else if (state_q == serial_bus_pkg::ST_DONE) begin
                transferBusy_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // shift register and status flags

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            serialShiftData_q <= `SHIFT_DATA_RESET;
        end else if (ce) begin
            if (wrData) begin
                serialShiftData_q <= pwdata[7:0];
            end else if (dataEnd) begin
                serialShiftData_q <= {serialShiftData_q[6:0], sdaF};
            end
        end
    end

    wire mismatch = dataEnd && transferDirection_q
                    && (sdaF != serialShiftData_q[7]);
    wire missedAck = bitEnd && ackBit && busMode
                     && transferDirection_q && sdaF;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            verifyFlag_q <= 1'b0;
            noAckFlag_q  <= 1'b0;
        end else if (ce) begin
            if (startByte) begin
                verifyFlag_q <= newDir && busMode;
                noAckFlag_q  <= 1'b0;
            end else begin
                if (mismatch && busMode) begin
                    verifyFlag_q <= 1'b0;
                end
                if (missedAck) begin
                    noAckFlag_q <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pin drive: a one pulls the open-drain line low

    always_comb begin
        sclLowD = sclOe;
        sdaLowD = sdaOe;
        enLowD  = enableLineOe;
        case (state_q)
            serial_bus_pkg::ST_START: begin
                sclLowD = phase_q == 2'd0 || phase_q == 2'd3;
                if (threeWire) begin
                    sdaLowD = 1'b0;
                    enLowD  = phase_q[1];
                end else begin
                    sdaLowD = phase_q[1];
                    enLowD  = 1'b0;
                end
            end
            serial_bus_pkg::ST_BIT: begin
                sclLowD = !phase_q[1];
                enLowD  = 1'b0;
                if (phase_q == 2'd0 || phase_q[1]) begin
                    sdaLowD = sdaOe;
                end
                if (phase_q == 2'd0) begin
                    // data moves only while the clock is low
                    if (txData) begin
                        sdaLowD = !serialShiftData_q[7];
                    end else if (ackBit && !transferDirection_q) begin
                        sdaLowD = !stopGenEnable_q;
                    end else begin
                        sdaLowD = 1'b0;
                    end
                end
            end
            serial_bus_pkg::ST_STOP: begin
                sclLowD = phase_q == 2'd0;
                if (threeWire) begin
                    sdaLowD = 1'b0;
                    enLowD  = !phase_q[1] || phase_q == 2'd2;
                end else begin
                    sdaLowD = !phase_q[1] || phase_q == 2'd2;
                end
                if (phase_q == 2'd3) begin
                    sdaLowD = 1'b0;
                    enLowD  = 1'b0;
                end
            end
            serial_bus_pkg::ST_DONE: begin
                if (shiftMode) begin
                    sclLowD = 1'b0;
                    sdaLowD = 1'b0;
                end
            end
            default: begin
                sclLowD = sclOe;
            end
        endcase
        // data and enable wait one cycle after the clock is pulled low
        if (sclLowD && !sclOe) begin
            sdaLowD = sdaOe;
            enLowD  = enableLineOe;
        end
        if (modeOff) begin
            sclLowD = 1'b0;
            sdaLowD = 1'b0;
            enLowD  = 1'b0;
        end
        if (!threeWire) begin
            enLowD = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sclOe         <= 1'b0;
            sdaOe         <= 1'b0;
            enableLineOe  <= 1'b0;
            sclOut        <= 1'b1;
            sdaOut        <= 1'b1;
            enableLineOut <= 1'b1;
        end else if (ce) begin
            sclOe         <= sclLowD;
            sdaOe         <= sdaLowD;
            enableLineOe  <= enLowD;
            sclOut        <= !sclLowD;
            sdaOut        <= !sdaLowD;
            enableLineOut <= !enLowD;
        end
    end

endmodule

// *** test/serial_bus_chk.sv ***
// checker for the serial port pins and register reads
// assumes a bind onto the port's top module
`include "serial_bus_params.svh"
module serial_bus_chk (
    input wire logic        mclk,          // clock
    input wire logic        rst_n,         // reset
    input wire logic        psel,          // apb
    input wire logic        penable,       // apb
    input wire logic        pwrite,        // apb
    input wire logic [11:0] paddr,         // apb
    input wire logic [31:0] pwdata,        // apb
    input wire logic [31:0] prdata,        // apb
    input wire logic        pready,        // apb
    input wire logic        sclOe,         // clock pulled
    input wire logic        sdaOe,         // data pulled
    input wire logic        enableLineOe,  // enable pulled
    input wire logic        sclOut,        // clock value
    input wire logic        sdaOut,        // data value
    input wire logic        enableLineOut, // enable value
    input wire logic        vsyncIntEnable // vsync enable
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0]  protoQ;
    logic [15:0] relCnt;
    wire         done = psel && penable && pready;
    wire         wrP  = done && pwrite && paddr == `ADDR_PROTO_CTRL;
    wire [3:0]   protoD = pwdata[3:0] | {2'b00, |pwdata[3:2], 1'b0};
    wire [1:0]   mode = protoQ[1:0];
    // mirror of the protocol register, released-clock cycle count
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            protoQ <= 4'h0;
            relCnt <= 16'hffff;
        end else begin
            if (wrP) protoQ <= protoD;
            if (sclOe) relCnt <= 16'h0;
            else if (relCnt != 16'hffff) relCnt <= relCnt + 16'h1;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_start;
        $rose(sdaOe) && !sclOe && !$past(sclOe);
    endsequence
    sequence s_stop;
        $fell(sdaOe) && !sclOe && !$past(sclOe);
    endsequence
    a_reset_released: assert property ($rose(rst_n) |->
        !sclOe && !sdaOe && !enableLineOe) else $error("pins after reset");
    a_off_released: assert property ((mode == 2'b00)[*2] |->
        !sclOe && !sdaOe && !enableLineOe) else $error("pins while off");
    a_enable_three_wire: assert property (enableLineOe |->
        mode == 2'b11 || $past(mode) == 2'b11) else $error("enable used");
    a_start_shape: assert property (s_start |->
        ##[490:510] $rose(sclOe)) else $error("start shape");
    a_stop_shape: assert property (s_stop |->
        (!sclOe && !sdaOe)[*8]) else $error("stop shape");
    a_scl_high_time: assert property ($rose(sclOe) && relCnt < 16'd2000
        |-> relCnt >= 16'd985 && relCnt <= 16'd1025) else $error("clock rate");
    a_vsync_write: assert property (done && pwrite &&
        paddr == `ADDR_XFER_CTRL |=> vsyncIntEnable == $past(pwdata[2]))
        else $error("vsync enable");
    a_proto_readback: assert property (done && !pwrite &&
        paddr == `ADDR_PROTO_CTRL |-> prdata == {28'h0, protoQ})
        else $error("protocol readback");
    a_out_inverse: assert property (sclOut != sclOe &&
        sdaOut != sdaOe && enableLineOut != enableLineOe)
        else $error("pin value and drive disagree");
    a_data_hold: assert property ($changed(sdaOe) ||
        $changed(enableLineOe) |-> !$changed(sclOe))
        else $error("data moved with clock");
endmodule
////////////////////////
bind serial_bus_master_port serial_bus_chk i_chk (
    .mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .sclOe, .sdaOe, .enableLineOe, .sclOut, .sdaOut,
    .enableLineOut, .vsyncIntEnable
);

// *** test/bus_slave_model.sv ***
// behavioural slave on the two-wire bus
// assumes wire levels resolved by the bench
module bus_slave_model (
    input  wire logic       scl,     // clock wire
    input  wire logic       sda,     // data wire
    input  wire logic       ackOn,   // acknowledge bytes
    input  wire logic       readOn,  // send txByte
    input  wire logic [7:0] txByte,  // byte to send
    output logic            sdaPull  // pulls data low
);
    timeunit 1ns;
    timeprecision 1ps;
    int   cnt = 0;
    logic act = 1'b0;
    initial sdaPull = 1'b0;
    always @(negedge sda) if (scl) begin
        act = 1'b1;
        cnt = 0;
    end
    always @(posedge sda) if (scl) act = 1'b0;
    always @(posedge scl) cnt = cnt + 1;
    always @(negedge scl) begin
        if (!act || cnt >= 9) begin
            cnt = 0;
            sdaPull = 1'b0;
        end else if (readOn) sdaPull = cnt < 8 && !txByte[7 - cnt];
        else sdaPull = cnt == 8 && ackOn;
    end
endmodule

// *** test/testbench.sv ***
// self-checking bench for the serial bus master port
// assumes the bound checker and a slave model on the bus
`include "serial_bus_params.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] PR = `ADDR_PROTO_CTRL;
    localparam logic [11:0] XF = `ADDR_XFER_CTRL;
    localparam logic [11:0] DT = `ADDR_SHIFT_DATA;
    logic        mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, ackOn = 1'b0, readOn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [7:0]  txByte = 8'h00;
    logic [9:0]  bits;
    logic        pready, pslverr, err, sclOe, sdaOe, slvPull, vsync, enOe;
    logic [3:0]  wv [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'hc};
    logic [3:0]  ev [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'ha, 4'he};
    wire         sclW = !sclOe;
    wire         sdaW = !sdaOe && !slvPull;
    wire         enW  = !enOe;
    int          error_cnt = 0, n_checks = 0;
    serial_bus_master_port i_dut (
        .mclk, .rst_n, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .sclIn(sclW), .sclOut(), .sclOe,
        .sdaIn(sdaW), .sdaOut(), .sdaOe, .enableLineOut(),
        .enableLineOe(enOe),
        .vsyncIntEnable(vsync)
    );
    bus_slave_model i_slave (
        .scl(sclW), .sda(sdaW), .ackOn, .readOn, .txByte, .sdaPull(slvPull)
    );
    always #4 mclk = ~mclk;
    always @(posedge sclW) bits <= {bits[8:0], sdaW};
    ////////////////////////
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        q   = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic check(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic waitIdle;
        int n;
        n = 0;
        do begin
            repeat (200) @(posedge mclk);
            apb(1'b0, XF, 32'h0);
            n++;
        end while (q[0] !== 1'b0 && n < 200);
        check("idle", 32'h0, {31'h0, q[0]});
        repeat (1500) @(posedge mclk);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    ////////////////////////
    initial begin
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        apb(1'b0, PR, 32'h0);
        check("proto reset", 32'h0, q);
        apb(1'b0, XF, 32'h0);
        check("xfer reset", 32'h0, q);
        apb(1'b1, XF, 32'h4);
        check("vsync", 32'h1, {31'h0, vsync});
        foreach (wv[i]) begin
            apb(1'b1, PR, {28'h0, wv[i]});
            apb(1'b0, PR, 32'h0);
            check("proto", {28'h0, ev[i]}, q);
        end
        apb(1'b0, 12'h00c, 32'h0);
        check("unmapped", 32'h1, {31'h0, err});
        $display("register test done");
        ackOn <= 1'b1;
        apb(1'b1, PR, 32'h0a);
        apb(1'b1, DT, 32'ha4);
        apb(1'b1, XF, 32'h9);
        apb(1'b0, XF, 32'h0);
        check("busy verify", 32'h5, q);
        apb(1'b0, DT, 32'h0);
        check("data blocked", 32'h1, {31'h0, err});
        waitIdle;
        check("address byte", 32'h148, {23'h0, bits[8:0]});
        apb(1'b0, XF, 32'h0);
        check("acked", 32'h4, q);
        $display("address test done");
        ackOn <= 1'b0;
        apb(1'b1, PR, 32'h07);
        apb(1'b1, DT, 32'h3c);
        apb(1'b1, XF, 32'h9);
        waitIdle;
        check("data byte", 32'h079, {23'h0, bits[9:1]});
        apb(1'b0, XF, 32'h0);
        check("no ack", 32'h6, q);
        check("bus free", 32'h7, {29'h0, sclW, sdaW, enW});
        $display("write test done");
        readOn <= 1'b1;
        txByte <= 8'h5a;
        apb(1'b1, PR, 32'h0e);
        apb(1'b1, XF, 32'h1);
        waitIdle;
        apb(1'b0, DT, 32'h0);
        check("read byte", 32'h5a, q);
        check("last no ack", 32'h0b5, {23'h0, bits[9:1]});
        $display("read test done");
        readOn <= 1'b0;
        apb(1'b1, PR, 32'h01);
        apb(1'b1, DT, 32'h81);
        apb(1'b1, XF, 32'h9);
        waitIdle;
        check("shift byte", 32'h81, {24'h0, bits[7:0]});
        apb(1'b1, PR, 32'h0);
        check("released", 32'h3, {30'h0, sclW, sdaW});
        $display("shift test done");
        tally_and_finish;
    end
    initial begin
        #(8 * 99000);
        error_cnt++;
        tally_and_finish;
    end
endmodule
